// File: src/omc_params.svh
// Constants for the operating mode controller
`ifndef OMC_PARAMS_SVH
`define OMC_PARAMS_SVH
// =====================================================
// Power saving configuration
`define OMC_PSV_W 2
`define OMC_PSV_OFF 2'h0
`define OMC_PSV_RTS 2'h2
// =====================================================
// Reset values
`define OMC_RST_LOW 1'h0
`define OMC_RST_HIGH 1'h1
`endif

// File: src/omc_pkg.sv
// Types for the operating mode controller
package omc_pkg;
  // =====================================================
  // Operating modes
  typedef enum logic [2:0] {
    NOT_POWERED,
    POWER_OFF,
    IDLE,
    ACTIVE,
    CONNECTED
  } omc_mode_type;
  // =====================================================
  // Registered status outputs
  typedef struct packed {
    logic switched_on;
    logic fast_ref_sel;
    logic slow_ref_sel;
    logic app_if_en;
    logic host_data_accept;
    logic cts_on;
    logic precharge_en;
    logic charge_ctrl_en;
  } omc_status_type;
endpackage : omc_pkg

// File: src/omc_top.sv
// Operating mode controller of the cellular module
`timescale 1ns/100ps
`include "omc_params.svh"
// Contract
// - Unpowered or low supply: ignore all switch-on triggers
// - Power-off: switch on by request falling edge, RTC alarm, charger
// - Orderly shutdown command enters power-off, interfaces closed
// - Idle runs processor from 32 kHz reference
// - Active and connected run from 26 MHz and accept host data
// - Enter idle whenever possible only with power saving; off after reset
// - Idle disables interfaces and refuses host data
// - Flow control on: CTS off while idle
// - Flow control off: CTS always on; the code holds CTS off while in reset
// - Registered and saving: wake at network paging times
// - Unregistered and saving: idle anyway, wake periodically
// - RTC alarm wakes idle to active
// - Serial receive data wakes idle to active
// - Incoming call wakes idle
// - RTS on wakes idle only with saving setting 2
// - Call keeps device active, then return to prior idle or active
// - Low battery with charger: stay off, force pre-charge
// - Normal battery with charger: run normally, processor charge control
// - Running device switches off below extended supply minimum
module omc_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supply_normal,
  input wire logic supply_extended_ok,
  input wire logic switch_on_request_n,
  input wire logic rtc_alarm,
  input wire logic charger_present,
  input wire logic orderly_shutdown_command,
  input wire logic power_saving_config_command,
  input wire logic [`OMC_PSV_W-1:0] power_saving_setting,
  input wire logic hw_flow_ctrl_en,
  input wire logic network_registered,
  input wire logic idle_possible,
  input wire logic paging_due,
  input wire logic activity_poll_due,
  input wire logic serial_rx_data,
  input wire logic rts_on,
  input wire logic incoming_call,
  input wire logic call_ended,
  output omc_pkg::omc_mode_type mode,
  output omc_pkg::omc_status_type status
);
  // =====================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= `OMC_RST_LOW;
      rst_n <= `OMC_RST_LOW;
    end else begin
      rst_meta_q <= `OMC_RST_HIGH;
      rst_n <= rst_meta_q;
    end
  end

  // =====================================================
  // Functions
  function automatic logic is_running(input omc_pkg::omc_mode_type m);
    is_running = (m == omc_pkg::IDLE) || (m == omc_pkg::ACTIVE) ||
                 (m == omc_pkg::CONNECTED);
  endfunction : is_running

  function automatic logic is_awake(input omc_pkg::omc_mode_type m);
    is_awake = (m == omc_pkg::ACTIVE) || (m == omc_pkg::CONNECTED);
  endfunction : is_awake

  // =====================================================
  // Next state
  omc_pkg::omc_mode_type mode_q;
  omc_pkg::omc_mode_type mode_d;
  omc_pkg::omc_mode_type ret_q;
  omc_pkg::omc_mode_type ret_d;
  logic [`OMC_PSV_W-1:0] psv_q;
  logic [`OMC_PSV_W-1:0] psv_d;
  logic req_prev_q;
  logic chg_prev_q;
  omc_pkg::omc_status_type status_q;
  omc_pkg::omc_status_type status_d;
  logic on_trigger;
  logic psv_en;
  logic idle_wake;

  always_comb begin
    on_trigger = (req_prev_q && !switch_on_request_n) || rtc_alarm ||
                 (charger_present && !chg_prev_q);
    psv_en = (psv_q != `OMC_PSV_OFF);
    idle_wake = rtc_alarm || serial_rx_data ||
                (rts_on && psv_q == `OMC_PSV_RTS) ||
                (network_registered && paging_due) ||
                (!network_registered && activity_poll_due);
    psv_d = psv_q;
    if (power_saving_config_command) begin
      psv_d = power_saving_setting;
    end
    ret_d = ret_q;
    mode_d = mode_q;
    case (mode_q)
      omc_pkg::NOT_POWERED: begin
        if (supply_normal) begin
          mode_d = omc_pkg::POWER_OFF;
        end
      end
      omc_pkg::POWER_OFF: begin
        if (!supply_normal) begin
          mode_d = omc_pkg::NOT_POWERED;
        end else if (on_trigger) begin
          mode_d = omc_pkg::ACTIVE;
        end
      end
      omc_pkg::IDLE: begin
        if (incoming_call) begin
          mode_d = omc_pkg::CONNECTED;
          ret_d = omc_pkg::IDLE;
        end else if (idle_wake || !psv_en) begin
          mode_d = omc_pkg::ACTIVE;
        end
      end
      omc_pkg::ACTIVE: begin
        if (incoming_call) begin
          mode_d = omc_pkg::CONNECTED;
          ret_d = omc_pkg::ACTIVE;
        end else if (psv_en && idle_possible) begin
          mode_d = omc_pkg::IDLE;
        end
      end
      omc_pkg::CONNECTED: begin
        if (call_ended) begin
          mode_d = ret_q;
        end
      end
      default: begin
        mode_d = omc_pkg::NOT_POWERED;
      end
    endcase
    if (is_running(mode_q)) begin
      if (!supply_extended_ok) begin
        mode_d = omc_pkg::NOT_POWERED;
      end else if (orderly_shutdown_command) begin
        mode_d = omc_pkg::POWER_OFF;
      end
    end
  end

  // =====================================================
  // Output decode
  always_comb begin
    status_d.switched_on = is_running(mode_d);
    status_d.fast_ref_sel = is_awake(mode_d);
    status_d.slow_ref_sel = (mode_d == omc_pkg::IDLE);
    status_d.app_if_en = is_awake(mode_d);
    status_d.host_data_accept = is_awake(mode_d);
    status_d.cts_on = hw_flow_ctrl_en ? is_awake(mode_d) :
                      `OMC_RST_HIGH;
    status_d.precharge_en = !is_running(mode_d) &&
                            !supply_normal && charger_present;
    status_d.charge_ctrl_en = is_running(mode_d) &&
                              supply_normal && charger_present;
  end

  // =====================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= omc_pkg::NOT_POWERED;
      ret_q <= omc_pkg::ACTIVE;
      psv_q <= `OMC_PSV_OFF;
      req_prev_q <= `OMC_RST_HIGH;
      chg_prev_q <= `OMC_RST_LOW;
      status_q <= '0;
    end else begin
      mode_q <= mode_d;
      ret_q <= ret_d;
      psv_q <= psv_d;
      req_prev_q <= switch_on_request_n;
      chg_prev_q <= charger_present;
      status_q <= status_d;
    end
  end

  assign mode = mode_q;
  assign status = status_q;

  // =====================================================
  // Checks
  chk_unpowered_ignore: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::NOT_POWERED && !supply_normal) |=>
      mode_q == omc_pkg::NOT_POWERED)
    else $error("Switched on without normal supply");

  chk_poweroff_wake: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::POWER_OFF && supply_normal && rtc_alarm) |=>
      mode_q == omc_pkg::ACTIVE)
    else $error("Power-off ignored switch-on trigger");

  chk_shutdown_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    (is_running(mode_q) && supply_extended_ok &&
     orderly_shutdown_command) |=>
      mode_q == omc_pkg::POWER_OFF && !status_q.app_if_en)
    else $error("Shutdown command not obeyed");

  chk_idle_clock: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(mode_q == omc_pkg::IDLE) |->
      status_q.slow_ref_sel && !status_q.fast_ref_sel)
    else $error("Idle not on slow reference");

  chk_idle_needs_psv: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::ACTIVE && psv_q == `OMC_PSV_OFF) |=>
      mode_q != omc_pkg::IDLE)
    else $error("Idle entered without power saving");

  chk_idle_refuse: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::IDLE) |->
      !status_q.host_data_accept && !status_q.app_if_en)
    else $error("Idle accepting host data");

  chk_cts_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_d == omc_pkg::IDLE && hw_flow_ctrl_en) |=> !status_q.cts_on)
    else $error("CTS on while idle");

  chk_cts_fixed: assert property (
    @(posedge clk) disable iff (!rst_n)
    !hw_flow_ctrl_en |=> status_q.cts_on)
    else $error("CTS off without flow control");

  chk_rx_wake: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::IDLE && serial_rx_data && !incoming_call &&
     supply_extended_ok && !orderly_shutdown_command) |=>
      mode_q == omc_pkg::ACTIVE && status_q.fast_ref_sel)
    else $error("Serial data did not wake idle");

  chk_rtc_wake: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::IDLE && rtc_alarm && !incoming_call &&
     supply_extended_ok && !orderly_shutdown_command) |=>
      mode_q == omc_pkg::ACTIVE)
    else $error("RTC alarm did not wake idle");

  chk_paging_wake: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::IDLE && network_registered && paging_due &&
     !incoming_call && supply_extended_ok && !orderly_shutdown_command)
      |=> mode_q == omc_pkg::ACTIVE)
    else $error("Paging time did not wake idle");

  chk_call_connect: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::IDLE && incoming_call && supply_extended_ok &&
     !orderly_shutdown_command) |=>
      mode_q == omc_pkg::CONNECTED && status_q.fast_ref_sel)
    else $error("Incoming call did not connect");

  chk_rts_setting: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::IDLE && psv_q != `OMC_PSV_RTS && psv_en &&
     rts_on && !rtc_alarm && !serial_rx_data && !paging_due &&
     !activity_poll_due && !incoming_call && supply_extended_ok &&
     !orderly_shutdown_command) |=> mode_q == omc_pkg::IDLE)
    else $error("Idle left without wake event");

  chk_call_return: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::IDLE && incoming_call && supply_extended_ok &&
     !orderly_shutdown_command) ##1 (call_ended && supply_extended_ok &&
     !orderly_shutdown_command) |=> mode_q == omc_pkg::IDLE)
    else $error("Call did not return to idle");

  chk_precharge: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::NOT_POWERED && !supply_normal &&
     charger_present) |=> status_q.precharge_en && !status_q.switched_on)
    else $error("Pre-charge not forced");

  chk_brownout_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    (is_running(mode_q) && !supply_extended_ok) |=>
      mode_q == omc_pkg::NOT_POWERED ##1 !status_q.switched_on)
    else $error("Running below extended supply");

  cov_switch_on: cover property (
    @(posedge clk) disable iff (!rst_n)
    mode_q == omc_pkg::POWER_OFF ##1 mode_q == omc_pkg::ACTIVE);

  cov_idle_cycle: cover property (
    @(posedge clk) disable iff (!rst_n)
    mode_q == omc_pkg::IDLE ##1 mode_q == omc_pkg::ACTIVE);

  cov_call: cover property (
    @(posedge clk) disable iff (!rst_n)
    mode_q == omc_pkg::CONNECTED ##1 mode_q == omc_pkg::IDLE);

  cov_shutdown: cover property (
    @(posedge clk) disable iff (!rst_n)
    mode_q == omc_pkg::ACTIVE ##1 mode_q == omc_pkg::POWER_OFF);

  cov_rts_wake: cover property (
    @(posedge clk) disable iff (!rst_n)
    (mode_q == omc_pkg::IDLE && psv_q == `OMC_PSV_RTS && rts_on) ##1
      mode_q == omc_pkg::ACTIVE);
endmodule : omc_top

// File: verif/omc_host_model.sv
// Host terminal model driving the power-on and serial lines
`timescale 1ns/100ps
module omc_host_model (
  input wire logic dev_on,
  input wire logic want_on,
  input wire logic want_rx,
  input wire logic want_rts,
  output logic switch_on_request_n,
  output logic serial_rx_data,
  output logic rts_on
);
  // =====================================================
  // Serial and RTS pins held low while the device is off; switch-on request follows want_on
  assign switch_on_request_n = !want_on;
  assign serial_rx_data = dev_on && want_rx;
  assign rts_on = dev_on && want_rts;
endmodule : omc_host_model

// File: verif/tb_top.sv
// Testbench of the operating mode controller
`timescale 1ns/100ps
module tb_top;
  // =====================================================
  // Stimulus bits and rows
  typedef struct {
    int in;
    omc_pkg::omc_mode_type md;
  } omc_row_type;
  localparam int sp = 1 << 17, ex = 1 << 16, on = 1 << 15, rt = 1 << 14;
  localparam int ch = 1 << 13, sd = 1 << 12, pc = 1 << 11, p2 = 1 << 10;
  localparam int p1 = 1 << 9, fc = 1 << 8, rg = 1 << 7, ip = 1 << 6;
  localparam int pg = 1 << 5, pl = 1 << 4, rx = 1 << 3, rs = 1 << 2;
  localparam int cl = 1 << 1, en = 1, p = sp | ex, f = p | fc;
  localparam omc_pkg::omc_mode_type np = omc_pkg::NOT_POWERED;
  localparam omc_pkg::omc_mode_type po = omc_pkg::POWER_OFF;
  localparam omc_pkg::omc_mode_type id = omc_pkg::IDLE;
  localparam omc_pkg::omc_mode_type ac = omc_pkg::ACTIVE;
  localparam omc_pkg::omc_mode_type cn = omc_pkg::CONNECTED;
  omc_row_type rows [31] = '{
    '{on, np}, '{rt | ch, np},
    '{p, po}, '{p | rt, ac}, '{p | sd, po},
    '{p | ch, ac}, '{p | ch | sd, po}, '{p, po},
    '{p | on, ac}, '{p | ip, ac}, '{p | pc | p1, ac},
    '{p | p1 | ip, id}, '{f | rx, ac}, '{f | ip, id},
    '{f | rt, ac}, '{f | ip, id}, '{f | rg | pg, ac},
    '{f | ip, id}, '{f | pl, ac}, '{f | ip, id},
    '{f | ip | rs, id}, '{f | ip | cl, cn}, '{f | ip, cn},
    '{f | ip | en, id}, '{f | ip | pc | p2, id}, '{f | rs, ac},
    '{f | cl, cn}, '{f | en, ac}, '{p | pc, ac}, '{p | ip, ac},
    '{sp, np}
  };
  logic clk;
  logic arst_n;
  logic [17:0] stim;
  logic son_n;
  logic rx_w;
  logic rts_w;
  omc_pkg::omc_mode_type mode;
  omc_pkg::omc_status_type status;
  int err_total = 0;
  int check_count = 0;
  // =====================================================
  // Design and host
  omc_host_model host (.dev_on(status.switched_on), .want_on(stim[15]),
    .want_rx(stim[3]), .want_rts(stim[2]), .switch_on_request_n(son_n),
    .serial_rx_data(rx_w), .rts_on(rts_w));
  omc_top uut (.clk(clk), .arst_n(arst_n), .supply_normal(stim[17]),
    .supply_extended_ok(stim[16]), .switch_on_request_n(son_n),
    .rtc_alarm(stim[14]), .charger_present(stim[13]),
    .orderly_shutdown_command(stim[12]),
    .power_saving_config_command(stim[11]),
    .power_saving_setting(stim[10:9]), .hw_flow_ctrl_en(stim[8]),
    .network_registered(stim[7]), .idle_possible(stim[6]),
    .paging_due(stim[5]), .activity_poll_due(stim[4]),
    .serial_rx_data(rx_w), .rts_on(rts_w), .incoming_call(stim[1]),
    .call_ended(stim[0]), .mode(mode), .status(status));
  // =====================================================
  // Expectation and compares
  function automatic omc_pkg::omc_status_type exp_st(
      omc_pkg::omc_mode_type m, logic f_on, logic c_on, logic s_on);
    logic up;
    logic act;
    up = m inside {id, ac, cn};
    act = up && m != id;
    return {up, act, m == id, act, act, !f_on || act,
            !up && !s_on && c_on, up && s_on && c_on};
  endfunction : exp_st
  task automatic chk_mode(omc_pkg::omc_mode_type got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_mode
  task automatic chk_status(omc_pkg::omc_status_type got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_status
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // =====================================================
  // Clock, watchdog and sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
  initial begin
    arst_n = 1'b0;
    stim = '0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      stim = rows[i].in[17:0];
      @(negedge clk);
      chk_mode(mode, rows[i].md);
      chk_status(status,
        exp_st(rows[i].md, stim[8], stim[13], stim[17]));
    end
    stim = p;
    @(negedge clk);
    stim = p | on;
    @(negedge clk);
    stim = p | pc | p1;
    @(negedge clk);
    chk_mode(mode, ac);
    arst_n = 1'b0;
    stim = p;
    #1;
    chk_mode(mode, np);
    chk_status(status, '0);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    stim = p | on;
    @(negedge clk);
    stim = p | ip;
    @(negedge clk);
    chk_mode(mode, ac);
    complete_run();
  end
endmodule : tb_top
